//--- design/lir_defines.vh
// constants for the bus controller register front end
`ifndef LIR_DEFINES_VH
`define LIR_DEFINES_VH
// special function register addresses
`define LIR_SFR_MODE        8'hc9
`define LIR_SFR_DATA        8'hd2
`define LIR_SFR_ADDR        8'hd3
// indirect addresses
`define LIR_IA_DATA_LAST    8'h07
`define LIR_IA_CTRL         8'h08
`define LIR_IA_STAT         8'h09
`define LIR_IA_ERR          8'h0a
`define LIR_IA_SIZE         8'h0b
`define LIR_IA_DIV          8'h0c
`define LIR_IA_MUL          8'h0d
`define LIR_IA_ID           8'h0e
// mode register fields and reset
`define LIR_MODE_EN         7
`define LIR_MODE_MASTER     6
`define LIR_MODE_AUTO       5
`define LIR_MODE_RST        8'h60
`define LIR_MODE_KEEP       8'he0
// control register bits
`define LIR_C_STOP          7
`define LIR_C_SLEEP         6
`define LIR_C_DIR           5
`define LIR_C_ACK           4
`define LIR_C_CLRINT        3
`define LIR_C_CLRERR        2
`define LIR_C_WAKE          1
`define LIR_C_START         0
// status register bits
`define LIR_S_ACTIVE        7
`define LIR_S_IDREQ         4
`define LIR_S_INT           3
`define LIR_S_ERROR         2
// masks
`define LIR_SLAVE_ONLY_CTRL 8'hd0
`define LIR_MASTER_ONLY_CTRL 8'h01
`define LIR_ERR_MASK        8'h1f
`define LIR_ID_MASK         8'h3f
`define LIR_ZERO            8'h00
`endif

//--- design/lir_top.v
// register front end of the serial bus controller, reached through mode, address and data sfrs
`timescale 1ns/1ps
`default_nettype none
`include "lir_defines.vh"

// Contract
// - data port read returns the core register the pointer selects
// - data port write stores into the core register the pointer selects
// - mode bit 7 enables controller; resets to zero
// - mode bit 6 selects master when one, slave when zero; resets to master
// - mode bit 5 selects automatic rate; resets one; only matters in slave role
// - mode low five bits read zero, writes ignored
// - indirect 0x00 to 0x07 are eight data bytes, reset zero
// - fifteen indirect registers from data bytes up to identifier at 0x0e
// - master-only bits usable in master role, slave-only bits in slave role
// - stop bit pulses halt until next sync break; reads zero
// - sleep bit in slave role sleeps node; clearing wakes it
// - direction bit: one transmits response, zero receives
// - slave acknowledge bit set by software, cleared by controller
// - writing one to bit 3 clears pending interrupt; reads zero
// - writing one to bit 2 clears status error bit and error flags; reads zero
// - wake request sends wakeup signal, controller clears it
// - master start request starts frame, cleared on completion or error
// - indirect address pointer is eight bits, resets zero
// - status bit 3 reads one while interrupt pending
// - slave access to data and identifier only when request pending, bus idle
module lir_top #(
   parameter NUM_BYTES = 8
) (
   // clock and reset
   input  wire        ref_clk,
   input  wire        reset,
   // special function register port
   input  wire [7:0]  sfr_addr,
   input  wire        sfr_wr,
   input  wire        sfr_rd,
   input  wire [7:0]  sfr_wdata,
   output reg  [7:0]  sfr_rdata_ff,
   // frame engine side
   input  wire        eng_done,
   input  wire        eng_error,
   input  wire        eng_ack_taken,
   input  wire        eng_wake_sent,
   input  wire        eng_sync_break,
   input  wire [7:0]  eng_status_set,
   input  wire [7:0]  eng_error_set,
   input  wire        eng_byte_we,
   input  wire [2:0]  eng_byte_idx,
   input  wire [7:0]  eng_byte_data,
   // control outputs
   output reg         controller_enable_ff,
   output reg         master_role_ff,
   output reg         auto_rate_select_ff,
   output reg         frame_direction_ff,
   output reg         sleep_ff,
   output reg         request_acknowledge_ff,
   output reg         wake_signal_request_ff,
   output reg         frame_start_request_ff,
   output reg         stop_pulse_ff,
   output reg         halted_ff,
   output reg  [7:0]  frame_length_checksum_ff,
   output reg  [7:0]  baud_divider_low_ff,
   output reg  [7:0]  baud_prescale_multiplier_ff,
   output reg  [7:0]  frame_identifier_ff
);

   //----------------------------------------
   // storage
   //----------------------------------------
   reg  [7:0] indirect_address_pointer_ff;
   reg  [7:0] frame_data_byte_ff [0:NUM_BYTES-1];
   reg  [7:0] bus_status_ff;
   reg  [7:0] bus_error_flags_ff;

   //----------------------------------------
   // decode
   //----------------------------------------
   wire       wr_mode = sfr_wr && (sfr_addr == `LIR_SFR_MODE);
   wire       wr_ptr  = sfr_wr && (sfr_addr == `LIR_SFR_ADDR);
   wire       wr_dat  = sfr_wr && (sfr_addr == `LIR_SFR_DATA);
   wire [7:0] ptr     = indirect_address_pointer_ff;
   wire       slave   = ~master_role_ff;

   // slave buffer access needs pending request and quiet bus
   function buf_ok;
      input sl;
      input [7:0] st;
      begin
         buf_ok = ~sl | (st[`LIR_S_IDREQ] & ~st[`LIR_S_ACTIVE]);
      end
   endfunction

   function is_data;
      input [7:0] a;
      begin
         is_data = (a <= `LIR_IA_DATA_LAST);
      end
   endfunction

   wire access_ok = buf_ok(slave, bus_status_ff);
   wire wr_ctrl   = wr_dat && (ptr == `LIR_IA_CTRL);
   // role masking of control writes
   wire [7:0] ctrl_mask = master_role_ff ? ~`LIR_SLAVE_ONLY_CTRL : ~`LIR_MASTER_ONLY_CTRL;
   wire [7:0] ctrl_w    = sfr_wdata & ctrl_mask;
   wire       clr_err   = wr_ctrl && ctrl_w[`LIR_C_CLRERR];
   wire       clr_int   = wr_ctrl && ctrl_w[`LIR_C_CLRINT];

   //----------------------------------------
   // direct registers
   //----------------------------------------
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         indirect_address_pointer_ff <= `LIR_ZERO;
         controller_enable_ff        <= 1'b0;
         master_role_ff              <= 1'b1;
         auto_rate_select_ff         <= 1'b1;
      end else begin
         if (wr_ptr)
            indirect_address_pointer_ff <= sfr_wdata;
         if (wr_mode) begin
            // low bits have no storage at all
            controller_enable_ff <= sfr_wdata[`LIR_MODE_EN];
            master_role_ff       <= sfr_wdata[`LIR_MODE_MASTER];
            auto_rate_select_ff  <= sfr_wdata[`LIR_MODE_AUTO];
         end
      end
   end

   //----------------------------------------
   // data bytes
   //----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BYTES; gi = gi + 1) begin : g_byte
         always @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               frame_data_byte_ff[gi] <= `LIR_ZERO;
            end else if (wr_dat && is_data(ptr) && access_ok && ptr[2:0] == gi) begin
               frame_data_byte_ff[gi] <= sfr_wdata;
            end else if (eng_byte_we && eng_byte_idx == gi) begin
               frame_data_byte_ff[gi] <= eng_byte_data;
            end
         end
      end
   endgenerate

   //----------------------------------------
   // config registers
   //----------------------------------------
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         frame_length_checksum_ff    <= `LIR_ZERO;
         baud_divider_low_ff         <= `LIR_ZERO;
         baud_prescale_multiplier_ff <= `LIR_ZERO;
         frame_identifier_ff         <= `LIR_ZERO;
      end else if (wr_dat) begin
         case (ptr)
            `LIR_IA_SIZE: frame_length_checksum_ff    <= sfr_wdata;
            `LIR_IA_DIV:  baud_divider_low_ff         <= sfr_wdata;
            `LIR_IA_MUL:  baud_prescale_multiplier_ff <= sfr_wdata;
            `LIR_IA_ID: begin
               if (access_ok)
                  frame_identifier_ff <= sfr_wdata & `LIR_ID_MASK;
            end
            default: ;
         endcase
      end
   end

   //----------------------------------------
   // control bits
   //----------------------------------------
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         frame_direction_ff     <= 1'b0;
         sleep_ff               <= 1'b0;
         request_acknowledge_ff <= 1'b0;
         wake_signal_request_ff <= 1'b0;
         frame_start_request_ff <= 1'b0;
         stop_pulse_ff          <= 1'b0;
         halted_ff              <= 1'b0;
      end else begin
         stop_pulse_ff <= wr_ctrl && ctrl_w[`LIR_C_STOP];
         // sync break releases; a new stop in the same cycle wins
         if (wr_ctrl && ctrl_w[`LIR_C_STOP])
            halted_ff <= 1'b1;
         else if (eng_sync_break)
            halted_ff <= 1'b0;
         if (wr_ctrl) begin
            frame_direction_ff <= ctrl_w[`LIR_C_DIR];
            if (slave)
               sleep_ff <= ctrl_w[`LIR_C_SLEEP];
         end
         // software set wins over the engine clear
         if (wr_ctrl && ctrl_w[`LIR_C_ACK])
            request_acknowledge_ff <= 1'b1;
         else if (eng_ack_taken)
            request_acknowledge_ff <= 1'b0;
         if (wr_ctrl && ctrl_w[`LIR_C_WAKE])
            wake_signal_request_ff <= 1'b1;
         else if (eng_wake_sent || eng_error)
            wake_signal_request_ff <= 1'b0;
         if (wr_ctrl && ctrl_w[`LIR_C_START])
            frame_start_request_ff <= 1'b1;
         else if (eng_done || eng_error)
            frame_start_request_ff <= 1'b0;
      end
   end

   //----------------------------------------
   // status and error flags
   //----------------------------------------
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         bus_status_ff      <= `LIR_ZERO;
         bus_error_flags_ff <= `LIR_ZERO;
      end else begin
         // set wins over clear so no event is lost
         bus_status_ff <= (bus_status_ff
                           & ~({7'h00, clr_int} << `LIR_S_INT)
                           & ~({7'h00, clr_err} << `LIR_S_ERROR))
                          | eng_status_set
                          | ({7'h00, eng_error} << `LIR_S_ERROR);
         bus_error_flags_ff <= ((clr_err ? `LIR_ZERO : bus_error_flags_ff)
                                | eng_error_set) & `LIR_ERR_MASK;
      end
   end

   //----------------------------------------
   // read mux
   //----------------------------------------
   reg [7:0] nxt_rdata;
   reg [7:0] ind;
   always @* begin
      ind = `LIR_ZERO;
      if (is_data(ptr)) begin
         ind = access_ok ? frame_data_byte_ff[ptr[2:0]] : `LIR_ZERO;
      end else begin
         case (ptr)
            `LIR_IA_CTRL: ind = {1'b0, sleep_ff, frame_direction_ff, request_acknowledge_ff,
                                 2'b00, wake_signal_request_ff, frame_start_request_ff};
            `LIR_IA_STAT: ind = bus_status_ff;
            `LIR_IA_ERR:  ind = bus_error_flags_ff;
            `LIR_IA_SIZE: ind = frame_length_checksum_ff;
            `LIR_IA_DIV:  ind = baud_divider_low_ff;
            `LIR_IA_MUL:  ind = baud_prescale_multiplier_ff;
            `LIR_IA_ID:   ind = access_ok ? frame_identifier_ff : `LIR_ZERO;
            default:      ind = `LIR_ZERO;
         endcase
      end
      nxt_rdata = `LIR_ZERO;
      if (sfr_rd) begin
         case (sfr_addr)
            `LIR_SFR_MODE: nxt_rdata = {controller_enable_ff, master_role_ff,
                                        auto_rate_select_ff, 5'h00} & `LIR_MODE_KEEP;
            `LIR_SFR_ADDR: nxt_rdata = indirect_address_pointer_ff;
            `LIR_SFR_DATA: nxt_rdata = ind;
            default:       nxt_rdata = `LIR_ZERO;
         endcase
      end
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         sfr_rdata_ff <= `LIR_ZERO;
      else
         sfr_rdata_ff <= nxt_rdata;
   end

endmodule // lir_top
`default_nettype wire

//--- bench/lir_checker.sv
// port assertions for the register front end
`timescale 1ns/1ps
`default_nettype none
module lir_checker (
   // watched ports
   input wire logic       ref_clk, reset, sfr_wr, sfr_rd,
   input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_ff,
   input wire logic       eng_done, eng_error, eng_ack_taken, eng_wake_sent, eng_sync_break,
   input wire logic       controller_enable_ff, master_role_ff, auto_rate_select_ff,
   input wire logic       request_acknowledge_ff, wake_signal_request_ff, frame_start_request_ff, halted_ff,
   input wire logic       stop_pulse_ff
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   a_mode_low_zero: assert property (sfr_rd && sfr_addr == 8'hc9 |=> sfr_rdata_ff[4:0] == 5'h00)
      else $error("mode low bits not zero");
   a_idle_read_zero: assert property (!sfr_rd |=> sfr_rdata_ff == 8'h00)
      else $error("read data outside a read");
   a_mode_write_kept: assert property (sfr_wr && sfr_addr == 8'hc9 |=>
      {5'h00, controller_enable_ff, master_role_ff, auto_rate_select_ff} == ($past(sfr_wdata) >> 5))
      else $error("mode bits not stored");
   a_reset_mode: assert property ($fell(reset) |-> master_role_ff && auto_rate_select_ff && !controller_enable_ff)
      else $error("mode reset value wrong");
   a_start_end_clear: assert property (frame_start_request_ff && (eng_done || eng_error) && !sfr_wr
      |=> !frame_start_request_ff) else $error("start request not cleared");
   a_slave_no_start: assert property (!master_role_ff && !frame_start_request_ff |=> !frame_start_request_ff)
      else $error("start request in slave role");
   a_ack_auto_clear: assert property (request_acknowledge_ff && eng_ack_taken && !sfr_wr
      |=> !request_acknowledge_ff) else $error("acknowledge not cleared");
   a_wake_auto_clear: assert property (wake_signal_request_ff && eng_wake_sent && !sfr_wr
      |=> !wake_signal_request_ff) else $error("wake request not cleared");
   a_halt_break_end: assert property (halted_ff && eng_sync_break && !sfr_wr |=> !halted_ff)
      else $error("halt outlived sync break");
   a_stop_sets_halt: assert property (stop_pulse_ff |-> halted_ff)
      else $error("stop pulse without halt");
   c_frame_done: cover property (frame_start_request_ff && eng_done);
   c_ack_taken: cover property (request_acknowledge_ff && eng_ack_taken);
   c_halt_end: cover property (halted_ff && eng_sync_break);
endmodule // lir_checker
bind lir_top lir_checker chk_u (.ref_clk, .reset, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata_ff,
   .eng_done, .eng_error, .eng_ack_taken, .eng_wake_sent, .eng_sync_break, .controller_enable_ff,
   .master_role_ff, .auto_rate_select_ff, .request_acknowledge_ff, .wake_signal_request_ff,
   .frame_start_request_ff, .halted_ff, .stop_pulse_ff);
`default_nettype wire

//--- bench/lir_engine_model.sv
// frame engine stand-in answering control requests
`timescale 1ns/1ps
`default_nettype none
module lir_engine_model (
   // clock and reset
   input  wire logic       ref_clk, reset,
   // requests, fail makes the next frame end in error
   input  wire logic       start, wake, ack, halted, fail,
   // answers, pulses of one cycle
   output var  logic       done, error, ack_taken, wake_sent, sync_break,
   output var  logic [7:0] status_set, error_set
);
   reg  [2:0] cnt_ff;
   wire       hit = (cnt_ff == 3'h3);
   // answer some cycles late, never at once
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt_ff <= 3'h0;
         {done, error, ack_taken, wake_sent, sync_break} <= 5'h00;
         status_set <= 8'h00;
         error_set <= 8'h00;
      end else begin
         cnt_ff <= (start | wake | ack | halted) ? cnt_ff + 3'h1 : 3'h0;
         done <= hit & start & ~fail;
         error <= hit & start & fail;
         ack_taken <= hit & ack;
         wake_sent <= hit & wake;
         sync_break <= hit & halted;
         status_set <= (hit & start) ? (fail ? 8'h0c : 8'h09) : 8'h00;
         error_set <= (hit & start & fail) ? 8'h04 : 8'h00;
      end
   end
endmodule // lir_engine_model
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the register front end
`timescale 1ns/1ps
`default_nettype none
module tb;
   reg          ref_clk, reset, sfr_wr, sfr_rd, fail;
   reg  [7:0]   sfr_addr, sfr_wdata;
   reg  [7:0]   m [0:15];
   reg  [31:0]  seed;
   wire [7:0]   rdata, st_set, er_set, sz, dv, ml, idr;
   wire         en, ms, au, dir, slp, ack, wk, stq, hlt, dn, er, ak, ws, sb;
   integer      n_mismatch, checks, i;
   lir_top dut_u (.ref_clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_ff(rdata),
      .eng_done(dn), .eng_error(er), .eng_ack_taken(ak), .eng_wake_sent(ws), .eng_sync_break(sb),
      .eng_status_set(st_set), .eng_error_set(er_set), .eng_byte_we(1'b0), .eng_byte_idx(3'h0),
      .eng_byte_data(8'h00), .controller_enable_ff(en), .master_role_ff(ms), .auto_rate_select_ff(au),
      .frame_direction_ff(dir), .sleep_ff(slp), .request_acknowledge_ff(ack), .wake_signal_request_ff(wk),
      .frame_start_request_ff(stq), .stop_pulse_ff(), .halted_ff(hlt), .frame_length_checksum_ff(sz),
      .baud_divider_low_ff(dv), .baud_prescale_multiplier_ff(ml), .frame_identifier_ff(idr));
   lir_engine_model eng_u (.ref_clk, .reset, .start(stq), .wake(wk), .ack(ack), .halted(hlt), .fail,
      .done(dn), .error(er), .ack_taken(ak), .wake_sent(ws), .sync_break(sb), .status_set(st_set),
      .error_set(er_set));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   function [31:0] xs(input [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   function pick(input integer k);
      pick = (k == 0) ? stq : (k == 1) ? wk : (k == 2) ? ack : hlt;
   endfunction
   // ------------------------------------------------
   // bus cycles, one idle edge after each strobe
   // ------------------------------------------------
   task tick;
      @(posedge ref_clk);
      #1;
   endtask
   task chk(input [7:0] g, input [7:0] e);
      checks = checks + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick;
      sfr_wr = 1'b0;
      tick;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick;
      sfr_rd = 1'b0;
      chk(rdata, e);
      tick;
   endtask
   task iw(input [7:0] a, input [7:0] d);
      wr(8'hd3, a);
      wr(8'hd2, d);
   endtask
   task ir(input [7:0] a, input [7:0] e);
      wr(8'hd3, a);
      rd(8'hd2, e);
   endtask
   task wt(input integer k);
      integer n;
      for (n = 0; n < 20 && pick(k) !== 1'b0; n = n + 1) tick;
      chk({7'h00, pick(k)}, 8'h00);
      if (pick(k) !== 1'b0) close_out;
   endtask
   task close_out;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, fail, n_mismatch, checks} = 0;
      seed = 60;
      reset = 1'b1;
      for (i = 0; i < 16; i = i + 1) m[i] = 8'h00;
      repeat (20) @(posedge ref_clk);
      #1 reset = 1'b0;
      rd(8'hc9, 8'h60);
      rd(8'hd3, 8'h00);
      wr(8'hc9, 8'hff);
      rd(8'hc9, 8'he0);
      wr(8'hc9, 8'hc0);
      chk({5'h00, en, ms, au}, 8'h06);
      for (i = 0; i < 16; i = i + 1) if (i != 8) begin
         seed = xs(seed);
         iw(i[7:0], seed[7:0]);
         if (i < 8 || (i > 10 && i < 15)) m[i] = (i == 14) ? seed[7:0] & 8'h3f : seed[7:0];
      end
      for (i = 0; i < 16; i = i + 1) ir(i[7:0], m[i]);
      chk(sz, m[11]);
      chk(dv, m[12]);
      chk(ml, m[13]);
      chk(idr, m[14]);
      iw(8'h08, 8'h01);
      chk({7'h00, stq}, 8'h01);
      wt(0);
      ir(8'h09, 8'h09);
      iw(8'h08, 8'h08);
      ir(8'h09, 8'h01);
      fail = 1'b1;
      iw(8'h08, 8'h01);
      wt(0);
      ir(8'h09, 8'h0d);
      ir(8'h0a, 8'h04);
      iw(8'h08, 8'h04);
      ir(8'h09, 8'h09);
      ir(8'h0a, 8'h00);
      fail = 1'b0;
      iw(8'h08, 8'h02);
      chk({7'h00, wk}, 8'h01);
      wt(1);
      wr(8'hc9, 8'h80);
      iw(8'h08, 8'h01);
      chk({7'h00, stq}, 8'h00);
      iw(8'h08, 8'h70);
      chk({5'h00, slp, dir, ack}, 8'h07);
      wt(2);
      ir(8'h08, 8'h60);
      iw(8'h08, 8'h80);
      chk({7'h00, hlt}, 8'h01);
      wt(3);
      iw(8'h08, 8'h00);
      chk({6'h00, slp, dir}, 8'h00);
      iw(8'h00, 8'h5a);
      ir(8'h00, 8'h00);
      wr(8'hc9, 8'hc0);
      ir(8'h00, m[0]);
      close_out;
   end
endmodule // tb
`default_nettype wire
